//--- bench/lcdp_checker.sv
// Purpose: Port assertions for the LCD host port block
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Bound to lcdp_top at the foot of this file
`timescale 1ns/1ps
module lcdp_checker (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RSTN,
    // Parallel bus
    input wire logic REGISTER_SELECT,
    input wire logic RW,
    input wire logic ENABLE,
    input wire logic DB_OE,
    // Power controls
    input wire logic POWER_DOWN_PIN,
    input wire logic ICON_ONLY_SELECT,
    input wire logic DIRECT_MODE,
    input wire logic GEN_ENABLE,
    input wire logic DISPLAY_ENABLE,
    // Register bus
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RSTN);

    // Bus turned round only for an enabled read, never in power-down
    AST_OE_MATCH: assert property (
        DB_OE == (ENABLE && RW && !POWER_DOWN_PIN))
        else $error("bus drive enable mismatch");
    // Display only follows an instruction write taken at a strobe fall
    AST_DISP_CAUSE: assert property (
        $changed(DISPLAY_ENABLE) && $stable(POWER_DOWN_PIN) |->
        $past(ENABLE, 2) && !$past(ENABLE) && !$past(RW) &&
        !$past(REGISTER_SELECT) && !$past(POWER_DOWN_PIN))
        else $error("display enable changed without instruction");
    // Power controls move only while a register write is in flight
    AST_ICON_CAUSE: assert property (
        $changed(ICON_ONLY_SELECT) |-> !S_AXI_AWREADY || S_AXI_BVALID)
        else $error("icon select changed without write");
    AST_DIRECT_CAUSE: assert property (
        $changed(DIRECT_MODE) |-> !S_AXI_AWREADY || S_AXI_BVALID)
        else $error("direct mode changed without write");
    AST_GEN_CAUSE: assert property (
        $changed(GEN_ENABLE) && $stable(POWER_DOWN_PIN) |->
        !S_AXI_AWREADY || S_AXI_BVALID)
        else $error("generator changed without write");
    // Power-down silences generator, display and bus drive at once
    AST_PD_QUIET: assert property (
        POWER_DOWN_PIN |-> !GEN_ENABLE && !DISPLAY_ENABLE && !DB_OE)
        else $error("activity during power-down");
    // Register bus: read answered next cycle, one at a time
    AST_R_NEXT: assert property (
        S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
        else $error("read answer late");
    AST_B_BUSY: assert property (
        S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("write accepted while response pending");
endmodule // lcdp_checker

bind lcdp_top lcdp_checker u_chk (
    .CORE_CLK(CORE_CLK), .RSTN(RSTN), .REGISTER_SELECT(REGISTER_SELECT),
    .RW(RW), .ENABLE(ENABLE), .DB_OE(DB_OE),
    .POWER_DOWN_PIN(POWER_DOWN_PIN), .ICON_ONLY_SELECT(ICON_ONLY_SELECT),
    .DIRECT_MODE(DIRECT_MODE), .GEN_ENABLE(GEN_ENABLE),
    .DISPLAY_ENABLE(DISPLAY_ENABLE), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RVALID(S_AXI_RVALID)
);

//--- bench/lcdp_host.sv
// Purpose: Host controller model on the parallel bus, 4-bit hookup
// Assumes: Strobe timing counted in clock cycles
// Notes:   Lower data lines are unconnected and float
`timescale 1ns/1ps
module lcdp_host #(
    parameter int HI_CYC = 10,
    parameter int LO_CYC = 10
) (
    // Clock
    input  wire logic       clk,
    // Parallel bus
    output logic            rs,
    output logic            rw,
    output logic            en,
    output wire logic [7:0] db,
    // Device read data
    input  wire logic [7:0] q
);
    logic [3:0] hi_q;
    logic [3:0] junk_q;

    // Strobe low from time zero so reset release sees no access
    initial begin
        rs = 1'b0;
        rw = 1'b0;
        en = 1'b0;
        hi_q = 4'h0;
        junk_q = 4'h0;
    end

    // Floating lines move every cycle, so they can never pass as data
    always @(posedge clk) junk_q <= junk_q + 4'h7;
    assign db = {hi_q, junk_q};

    // One strobe, 250 ns high and 250 ns low; select held past the fall
    task automatic nib(input logic sel, input logic [3:0] n);
        @(posedge clk);
        en <= 1'b1;
        rs <= sel;
        rw <= 1'b0;
        hi_q <= n;
        repeat (HI_CYC) @(posedge clk);
        en <= 1'b0;
        repeat (LO_CYC) @(posedge clk);
    endtask

    // Whole byte as two strobes, upper nibble first
    task automatic send(input logic sel, input logic [7:0] b);
        nib(sel, b[7:4]);
        nib(sel, b[3:0]);
    endtask

    // Read byte as two strobes; nibble taken late in the high phase
    task automatic recv(input logic sel, output logic [7:0] b);
        @(posedge clk);
        en <= 1'b1;
        rs <= sel;
        rw <= 1'b1;
        repeat (HI_CYC) @(posedge clk);
        b[7:4] = q[7:4];
        en <= 1'b0;
        repeat (LO_CYC) @(posedge clk);
        en <= 1'b1;
        repeat (HI_CYC) @(posedge clk);
        b[3:0] = q[7:4];
        en <= 1'b0;
        repeat (LO_CYC) @(posedge clk);
        rw <= 1'b0;
    endtask
endmodule // lcdp_host

//--- bench/tb_top.sv
// Purpose: Self-checking bench for the LCD host port block
// Assumes: Host model in 4-bit hookup, register bus master here
// Notes:   Runs the nibble start-up sequence, then power controls
`timescale 1ns/1ps
`include "lcdp_map.vh"
module tb_top;
    localparam logic [31:0] MSK = 32'h7F7F_07FF;
    logic        clk, rstn, rs, rw, en, pd, db_oe;
    logic        icon, direct, gen, disp;
    logic [7:0]  db, db_out;
    logic [3:0]  awaddr, araddr, wstrb;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    integer      err_count;
    integer      n_compared;

    // 40 MHz core clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    lcdp_top dut (
        .CORE_CLK(clk), .RSTN(rstn), .REGISTER_SELECT(rs), .RW(rw),
        .ENABLE(en), .DB_IN(db), .DB_OUT(db_out), .DB_OE(db_oe),
        .POWER_DOWN_PIN(pd), .ICON_ONLY_SELECT(icon),
        .DIRECT_MODE(direct), .GEN_ENABLE(gen), .DISPLAY_ENABLE(disp),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    lcdp_host host (.clk(clk), .rs(rs), .rw(rw), .en(en), .db(db),
                    .q(db_out));

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Address and data offered together, each released once taken
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                          output logic [1:0] r);
        integer n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n = n + 1;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid && n < 200);
        if (!bvalid) err_count = err_count + 1;
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        integer n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n = n + 1;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid && n < 200);
        if (!rvalid) err_count = err_count + 1;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic status(output logic [31:0] s);
        logic [1:0] r;
        axi_rd(`LCDP_OFS_STATUS, s, r);
    endtask

    task automatic peek(input logic [7:0] i, output logic [31:0] v);
        logic [1:0] r;
        axi_wr(`LCDP_OFS_PEEK_ADDR, {24'h0000_00, i}, r);
        axi_rd(`LCDP_OFS_PEEK_DATA, v, r);
    endtask

    // Defaults after reset, blank screen, unmapped access refused
    task automatic t_reset;
        logic [31:0] s;
        logic [1:0]  r;
        status(s);
        chk("reset status", 32'h0000_0041, s & MSK);
        chk("reset outputs", 32'h0000_0000, {icon, direct, gen, disp});
        peek(8'h00, s);
        chk("blank cell", 32'h0000_0020, s);
        axi_rd(4'h2, s, r);
        chk("unmapped resp", {30'h0, `LCDP_RESP_SLVERR}, {30'h0, r});
        chk("unmapped data", 32'h0000_0000, s);
    endtask

    // Width switch in one access, then function setup in two nibbles
    task automatic t_width;
        logic [31:0] s;
        host.nib(1'b0, 4'h2);
        status(s);
        chk("width after switch", 32'h0000_0000, s & 32'h0000_0401);
        host.nib(1'b0, 4'h2);
        status(s);
        chk("phase after upper", 32'h0000_0400, s & 32'h0000_0401);
        host.nib(1'b0, 4'h5);
        status(s);
        chk("two lines, raised", 32'h0000_0006, s & 32'h0000_0407);
        host.send(1'b0, 8'h20);
        status(s);
        chk("one line, base", 32'h0000_0000, s & 32'h0000_0407);
    endtask

    // Display control acts only on its second nibble; entry mode
    task automatic t_display;
        logic [31:0] s;
        host.nib(1'b0, 4'h0);
        chk("display after upper", 32'h0000_0000, disp);
        host.nib(1'b0, 4'hE);
        chk("display on", 32'h0000_0001, disp);
        status(s);
        chk("cursor, no blink", 32'h0000_0018, s & 32'h0000_0038);
        host.send(1'b0, 8'h06);
        status(s);
        chk("entry mode", 32'h0000_0040, s & 32'h0000_00C0);
    endtask

    // Two characters land in display memory, address steps by one
    task automatic t_data;
        logic [31:0] s;
        host.send(1'b1, 8'h50);
        host.send(1'b1, 8'h48);
        status(s);
        chk("address, no shift", 32'h0002_0000, s & 32'h7F7F_0100);
        peek(8'h00, s);
        chk("first code", 32'h0000_0050, s);
        peek(8'h01, s);
        chk("second code", 32'h0000_0048, s);
    endtask

    // Current saving: control bits, read-only write, power-down pin
    task automatic t_power;
        logic [31:0] s;
        logic [1:0]  r;
        // Supply is internal here, so generator and direct are allowed
        for (int i = 0; i < 3; i++) begin
            axi_wr(`LCDP_OFS_CTRL, 32'h0000_0001 << i, r);
            chk("power bits", 32'h0000_0001 << i, {gen, direct, icon});
        end
        axi_wr(`LCDP_OFS_STATUS, 32'hFFFF_FFFF, r);
        status(s);
        chk("status kept", 32'h0002_0058, s & MSK);
        @(posedge clk) pd <= 1'b1;
        host.nib(1'b0, 4'h0);
        chk("powered down", 32'h0000_0000, {gen, disp});
        status(s);
        chk("strobe ignored", 32'h0002_0258, s & MSK);
        @(posedge clk) pd <= 1'b0;
        @(posedge clk);
        chk("powered up", 32'h0000_0003, {gen, disp});
        host.send(1'b0, 8'h08);
        chk("display off", 32'h0000_0000, disp);
    endtask

    // Parallel reads: address as instruction read, then a stored code
    task automatic t_read;
        logic [7:0]  b;
        logic [31:0] s;
        host.recv(1'b0, b);
        chk("address read", 32'h0000_0002, {24'h00_0000, b});
        host.send(1'b0, 8'h80);
        host.recv(1'b1, b);
        chk("data read", 32'h0000_0050, {24'h00_0000, b});
        status(s);
        chk("after read", 32'h0001_0000, s & 32'h007F_0400);
    endtask

    task automatic print_verdict;
        if (err_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // All inputs defined at time zero; reset held ten cycles
    initial begin
        err_count = 0;
        n_compared = 0;
        rstn = 1'b0;
        pd = 1'b0;
        awaddr = 4'h0;
        araddr = 4'h0;
        wstrb = 4'hF;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        wdata = 32'h0000_0000;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        t_reset;
        t_width;
        t_display;
        t_data;
        t_power;
        t_read;
        print_verdict;
    end

    // About 20 strobes of 20 cycles plus bus traffic; roughly twenty times margin
    initial begin
        #250000;
        err_count = err_count + 1;
        print_verdict;
    end
endmodule // tb_top

//--- rtl/lcdp_map.vh
// Purpose: Constants for the character LCD parallel host port block
// Assumes: Included by bare name from the design files
// Notes:   Offsets are byte addresses on the AXI4-Lite register bus
`ifndef LCDP_MAP_VH
`define LCDP_MAP_VH

// Register byte offsets
`define LCDP_OFS_CTRL        4'h0
`define LCDP_OFS_STATUS      4'h4
`define LCDP_OFS_PEEK_ADDR   4'h8
`define LCDP_OFS_PEEK_DATA   4'hC

// Power control register fields
`define LCDP_CTRL_ICON       0
`define LCDP_CTRL_DIRECT     1
`define LCDP_CTRL_GEN        2
`define LCDP_CTRL_RST        3'h0

// Status register fields
`define LCDP_ST_WIDTH8       0
`define LCDP_ST_TWO_LINE     1
`define LCDP_ST_VSEL         2
`define LCDP_ST_DISP_ON      3
`define LCDP_ST_CURSOR       4
`define LCDP_ST_BLINK        5
`define LCDP_ST_INCR         6
`define LCDP_ST_SHIFT        7
`define LCDP_ST_RAM_SEL      8
`define LCDP_ST_PWR_DOWN     9
`define LCDP_ST_PHASE        10
`define LCDP_ST_AC_LSB       16
`define LCDP_ST_OFS_LSB      24

// Peek address fields
`define LCDP_PEEK_SEL        7
`define LCDP_PEEK_RST        8'h00

// Instruction bit positions (highest set bit names the instruction)
`define LCDP_I_DD_ADDR       7
`define LCDP_I_CG_ADDR       6
`define LCDP_I_FUNC          5
`define LCDP_I_SHIFT         4
`define LCDP_I_DISP          3
`define LCDP_I_ENTRY         2
`define LCDP_I_HOME          1
`define LCDP_I_CLEAR         0

// Function-setup fields
`define LCDP_F_WIDTH8        4
`define LCDP_F_TWO_LINE      2
`define LCDP_F_VSEL          0

// Reset values
`define LCDP_RST_WIDTH8      1'b1
`define LCDP_RST_INCR        1'b1
`define LCDP_BLANK_CODE      8'h20

// AXI responses
`define LCDP_RESP_OKAY       2'b00
`define LCDP_RESP_SLVERR     2'b10

`endif

//--- rtl/lcdp_ram.v
// Purpose: Flip-flop RAM with one write port and two read ports
// Assumes: Synchronous active-low reset; reads are combinational
// Notes:   Reset and clear both fill every entry with FILL
`timescale 1ns/1ps
module lcdp_ram #(
    parameter WIDTH = 8,
    parameter DEPTH = 80,
    parameter AW    = 7,
    parameter [WIDTH-1:0] FILL = 8'h20
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rstn,
    // Write side
    input  wire             clr,
    input  wire             we,
    input  wire [AW-1:0]    waddr,
    input  wire [WIDTH-1:0] wdata,
    // Read sides
    input  wire [AW-1:0]    raddr_a,
    output wire [WIDTH-1:0] rdata_a,
    input  wire [AW-1:0]    raddr_b,
    output wire [WIDTH-1:0] rdata_b
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    integer         i;

    // Whole-array fill in one cycle; cheap in flops, costly as area
    always @(posedge clk) begin
        if (!rstn || clr) begin
            for (i = 0; i < DEPTH; i = i + 1)
                mem_q[i] <= FILL;
        end else if (we && (waddr < DEPTH)) begin
            mem_q[waddr] <= wdata;
        end
    end

    // Out-of-range reads return the fill code
    assign rdata_a = (raddr_a < DEPTH) ? mem_q[raddr_a] : FILL;
    assign rdata_b = (raddr_b < DEPTH) ? mem_q[raddr_b] : FILL;
endmodule // lcdp_ram

//--- rtl/lcdp_top.v
// Purpose: Parallel command/data host port of a character LCD controller
// Assumes: Bus pins synchronous to CORE_CLK; AXI4-Lite for software
// Notes:   Each bus access is taken at the falling edge of ENABLE
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "lcdp_map.vh"

// Contract
// - Reset gives 8-bit width; first write whole
// - 4-bit width: two accesses, act after second
// - 8-bit function setup selecting 4-bit switches width
// - Function setup also sets lines and voltage
// - Display control turns display, cursor on
// - Entry mode: step address, cursor right, no shift
// - Data write stores code, address advances
// - Icon, display off, direct, power-down pin
module lcdp_top #(
    parameter DISP_DEPTH  = 80,
    parameter GLYPH_DEPTH = 128
) (
    // Clock and reset
    input  wire        CORE_CLK,
    input  wire        RSTN,
    // Parallel host bus
    input  wire        REGISTER_SELECT,
    input  wire        RW,
    input  wire        ENABLE,
    input  wire [7:0]  DB_IN,
    output wire [7:0]  DB_OUT,
    output wire        DB_OE,
    // Power controls
    input  wire        POWER_DOWN_PIN,
    output wire        ICON_ONLY_SELECT,
    output wire        DIRECT_MODE,
    output wire        GEN_ENABLE,
    output wire        DISPLAY_ENABLE,
    // AXI4-Lite write address and data
    input  wire [3:0]  S_AXI_AWADDR,
    input  wire        S_AXI_AWVALID,
    output wire        S_AXI_AWREADY,
    input  wire [31:0] S_AXI_WDATA,
    input  wire [3:0]  S_AXI_WSTRB,
    input  wire        S_AXI_WVALID,
    output wire        S_AXI_WREADY,
    // AXI4-Lite write response
    output wire [1:0]  S_AXI_BRESP,
    output wire        S_AXI_BVALID,
    input  wire        S_AXI_BREADY,
    // AXI4-Lite read
    input  wire [3:0]  S_AXI_ARADDR,
    input  wire        S_AXI_ARVALID,
    output wire        S_AXI_ARREADY,
    output wire [31:0] S_AXI_RDATA,
    output wire [1:0]  S_AXI_RRESP,
    output wire        S_AXI_RVALID,
    input  wire        S_AXI_RREADY
);
    localparam [6:0] DISP_LAST  = DISP_DEPTH[6:0] - 7'h01;
    localparam [6:0] GLYPH_LAST = GLYPH_DEPTH[6:0] - 7'h01;

    // Mode state
    reg        e_q;
    reg        width8_q;
    reg        phase_q;
    reg [3:0]  hi_q;
    reg        two_line_q;
    reg        vsel_q;
    reg        disp_on_q;
    reg        cursor_q;
    reg        blink_q;
    reg        incr_q;
    reg        shift_q;
    reg        ram_sel_q;
    reg [6:0]  ac_q;
    reg [6:0]  ofs_q;
    reg [7:0]  rd_hold_q;
    reg [7:0]  db_out_q;
    // Register file state
    reg [2:0]  ctrl_q;
    reg [7:0]  peek_q;
    reg        aw_got_q;
    reg        w_got_q;
    reg [3:0]  awaddr_q;
    reg [31:0] wdata_q;
    reg        wstrb0_q;
    reg        bvalid_q;
    reg [1:0]  bresp_q;
    reg        rvalid_q;
    reg [1:0]  rresp_q;
    reg [31:0] rdata_q;

    // Wrapping address step in either direction
    function [6:0] lcdp_step;
        input [6:0] v;
        input       up;
        input [6:0] last;
        begin
            if (up)
                lcdp_step = (v >= last) ? 7'h00 : v + 7'h01;
            else
                lcdp_step = (v == 7'h00) ? last : v - 7'h01;
        end
    endfunction

    // Access taken at ENABLE falling; power-down freezes the bus
    wire strobe    = e_q & ~ENABLE & ~POWER_DOWN_PIN;
    wire wr_stb    = strobe & ~RW;
    wire rd_stb    = strobe & RW;
    // Byte completes at once in 8-bit, else on the second nibble
    wire byte_done = wr_stb & (width8_q | phase_q);
    wire rd_done   = rd_stb & (width8_q | phase_q);
    // Lower lines ignored in nibble mode
    wire [7:0] wbyte = width8_q ? DB_IN
                                : {hi_q, DB_IN[7:4]};
    wire cmd     = byte_done & ~REGISTER_SELECT;
    wire dat_wr  = byte_done & REGISTER_SELECT;
    wire dat_rd  = rd_done & REGISTER_SELECT;
    wire do_clr  = cmd && (wbyte == 8'h01);
    wire [6:0] ac_last = ram_sel_q ? GLYPH_LAST : DISP_LAST;
    wire [6:0] ac_next = lcdp_step(ac_q, incr_q, ac_last);

    wire [7:0] disp_rd;
    wire [7:0] glyph_rd;
    wire [7:0] disp_peek;
    wire [7:0] glyph_peek;
    wire [7:0] ram_rd = ram_sel_q ? glyph_rd : disp_rd;
    // Busy is always clear: every instruction ends in one cycle
    wire [7:0] rd_src = REGISTER_SELECT ? ram_rd : {1'b0, ac_q};

    // Display and glyph stores
    lcdp_ram #(.WIDTH(8), .DEPTH(DISP_DEPTH), .AW(7),
               .FILL(`LCDP_BLANK_CODE)) u_disp (
        .clk     (CORE_CLK),
        .rstn    (RSTN),
        .clr     (do_clr),
        .we      (dat_wr & ~ram_sel_q),
        .waddr   (ac_q),
        .wdata   (wbyte),
        .raddr_a (ac_q),
        .rdata_a (disp_rd),
        .raddr_b (peek_q[6:0]),
        .rdata_b (disp_peek)
    );
    lcdp_ram #(.WIDTH(8), .DEPTH(GLYPH_DEPTH), .AW(7),
               .FILL(8'h00)) u_glyph (
        .clk     (CORE_CLK),
        .rstn    (RSTN),
        .clr     (1'b0),
        .we      (dat_wr & ram_sel_q),
        .waddr   (ac_q),
        .wdata   (wbyte),
        .raddr_a (ac_q),
        .rdata_a (glyph_rd),
        .raddr_b (peek_q[6:0]),
        .rdata_b (glyph_peek)
    );

    // Bus strobe tracking and nibble phase
    always @(posedge CORE_CLK) begin
        if (!RSTN) begin
            e_q     <= 1'b0;
            phase_q <= 1'b0;
            hi_q    <= 4'h0;
        end else begin
            e_q <= ENABLE;
            if (cmd && wbyte[7:5] == 3'b001 && width8_q) begin
                phase_q <= 1'b0;
            end else if (strobe && !width8_q) begin
                phase_q <= ~phase_q;
                if (!phase_q)
                    hi_q <= DB_IN[7:4];
            end
        end
    end

    // Instruction and data effects
    always @(posedge CORE_CLK) begin
        if (!RSTN) begin
            width8_q   <= `LCDP_RST_WIDTH8;
            two_line_q <= 1'b0;
            vsel_q     <= 1'b0;
            disp_on_q  <= 1'b0;
            cursor_q   <= 1'b0;
            blink_q    <= 1'b0;
            incr_q     <= `LCDP_RST_INCR;
            shift_q    <= 1'b0;
            ram_sel_q  <= 1'b0;
            ac_q       <= 7'h00;
            ofs_q      <= 7'h00;
        end else if (cmd) begin
            if (wbyte[`LCDP_I_DD_ADDR]) begin
                ac_q      <= wbyte[6:0];
                ram_sel_q <= 1'b0;
            end else if (wbyte[`LCDP_I_CG_ADDR]) begin
                ac_q      <= {1'b0, wbyte[5:0]};
                ram_sel_q <= 1'b1;
            end else if (wbyte[`LCDP_I_FUNC]) begin
                width8_q   <= wbyte[`LCDP_F_WIDTH8];
                two_line_q <= wbyte[`LCDP_F_TWO_LINE];
                vsel_q     <= wbyte[`LCDP_F_VSEL];
            end else if (wbyte[`LCDP_I_SHIFT]) begin
                if (wbyte[3])
                    ofs_q <= lcdp_step(ofs_q, wbyte[2], DISP_LAST);
                else
                    ac_q <= lcdp_step(ac_q, wbyte[2], ac_last);
            end else if (wbyte[`LCDP_I_DISP]) begin
                disp_on_q <= wbyte[2];
                cursor_q  <= wbyte[1];
                blink_q   <= wbyte[0];
            end else if (wbyte[`LCDP_I_ENTRY]) begin
                incr_q  <= wbyte[1];
                shift_q <= wbyte[0];
            end else if (wbyte[`LCDP_I_HOME]) begin
                ac_q      <= 7'h00;
                ofs_q     <= 7'h00;
                ram_sel_q <= 1'b0;
            end else if (wbyte[`LCDP_I_CLEAR]) begin
                ac_q      <= 7'h00;
                ofs_q     <= 7'h00;
                ram_sel_q <= 1'b0;
                incr_q    <= 1'b1;
            end
        end else if (dat_wr || dat_rd) begin
            ac_q <= ac_next;
            // Window moves only on writes to the display store
            if (dat_wr && shift_q && !ram_sel_q)
                ofs_q <= lcdp_step(ofs_q, incr_q, DISP_LAST);
        end
    end

    // Read path: byte frozen across its two nibbles
    always @(posedge CORE_CLK) begin
        if (!RSTN) begin
            rd_hold_q <= 8'h00;
            db_out_q  <= 8'h00;
        end else begin
            if (!phase_q)
                rd_hold_q <= rd_src;
            if (width8_q)
                db_out_q <= rd_src;
            else if (phase_q)
                db_out_q <= {rd_hold_q[3:0], 4'h0};
            else
                db_out_q <= {rd_src[7:4], 4'h0};
        end
    end

    assign DB_OUT = db_out_q;
    assign DB_OE  = ENABLE & RW & ~POWER_DOWN_PIN;

    // Power outputs; host keeps generator and direct off if external
    assign ICON_ONLY_SELECT = ctrl_q[`LCDP_CTRL_ICON];
    assign DIRECT_MODE      = ctrl_q[`LCDP_CTRL_DIRECT];
    assign GEN_ENABLE       = ctrl_q[`LCDP_CTRL_GEN] & ~POWER_DOWN_PIN;
    assign DISPLAY_ENABLE   = disp_on_q & ~POWER_DOWN_PIN;

    // Status word for software
    wire [31:0] status_w = {1'b0, ofs_q, 1'b0, ac_q, 5'h00, phase_q,
                            POWER_DOWN_PIN, ram_sel_q, shift_q, incr_q,
                            blink_q, cursor_q, disp_on_q, vsel_q,
                            two_line_q, width8_q};
    wire [7:0]  peek_w   = peek_q[`LCDP_PEEK_SEL] ? glyph_peek : disp_peek;

    // AXI write: address and data taken in either order
    assign S_AXI_AWREADY = ~aw_got_q & ~bvalid_q;
    assign S_AXI_WREADY  = ~w_got_q & ~bvalid_q;
    assign S_AXI_BVALID  = bvalid_q;
    assign S_AXI_BRESP   = bresp_q;

    always @(posedge CORE_CLK) begin
        if (!RSTN) begin
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q  <= 32'h0000_0000;
            wstrb0_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q  <= `LCDP_RESP_OKAY;
            ctrl_q   <= `LCDP_CTRL_RST;
            peek_q   <= `LCDP_PEEK_RST;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_got_q <= 1'b1;
                awaddr_q <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_got_q  <= 1'b1;
                wdata_q  <= S_AXI_WDATA;
                wstrb0_q <= S_AXI_WSTRB[0];
            end
            if (aw_got_q && w_got_q && !bvalid_q) begin
                aw_got_q <= 1'b0;
                w_got_q  <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= `LCDP_RESP_OKAY;
                case (awaddr_q)
                    `LCDP_OFS_CTRL: begin
                        if (wstrb0_q)
                            ctrl_q <= wdata_q[2:0];
                    end
                    `LCDP_OFS_PEEK_ADDR: begin
                        if (wstrb0_q)
                            peek_q <= wdata_q[7:0];
                    end
                    `LCDP_OFS_STATUS,
                    `LCDP_OFS_PEEK_DATA: begin
                        bresp_q <= `LCDP_RESP_OKAY;
                    end
                    default: begin
                        bresp_q <= `LCDP_RESP_SLVERR;
                    end
                endcase
            end else if (bvalid_q && S_AXI_BREADY) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // AXI read: one outstanding, answered the cycle after address
    assign S_AXI_ARREADY = ~rvalid_q;
    assign S_AXI_RVALID  = rvalid_q;
    assign S_AXI_RDATA   = rdata_q;
    assign S_AXI_RRESP   = rresp_q;

    always @(posedge CORE_CLK) begin
        if (!RSTN) begin
            rvalid_q <= 1'b0;
            rresp_q  <= `LCDP_RESP_OKAY;
            rdata_q  <= 32'h0000_0000;
        end else if (S_AXI_ARVALID && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rresp_q  <= `LCDP_RESP_OKAY;
            case (S_AXI_ARADDR)
                `LCDP_OFS_CTRL:      rdata_q <= {29'h0000_0000, ctrl_q};
                `LCDP_OFS_STATUS:    rdata_q <= status_w;
                `LCDP_OFS_PEEK_ADDR: rdata_q <= {24'h00_0000, peek_q};
                `LCDP_OFS_PEEK_DATA: rdata_q <= {24'h00_0000, peek_w};
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= `LCDP_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
        end
    end
endmodule // lcdp_top
